// >>> rtl/rtte_trip_elements.sv
`timescale 1ns/10ps
module rtte_trip_elements
    import rtte_pkg::*;
(
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic             enable,
    input  wire logic             cycleTick,
    input  wire rtte_meas_t       meas,
    input  wire rtte_bus_t        bus,
    output logic [DW-1:0]         readData,
    output logic [NEL-1:0]        pickup,
    output logic [NEL-1:0]        trip
);

    // Settings
    logic [15:0] pick_r [NEL];    // Pickup thresholds
    logic [13:0] dly_r  [NEL];    // Delays in line cycles
    logic [15:0] vSup_r;          // Voltage supervision
    logic [15:0] iSup_r;          // Current supervision
    logic [1:0]  cfg_r;           // Rotation and connection

    // Element state
    logic [13:0]    cnt_r [NEL];  // Cycle counters
    logic [NEL-1:0] pu_r;         // Pickup flags
    logic [NEL-1:0] pu_nxt;       // Next pickup flags
    logic [NEL-1:0] tr_r;         // Trip flags
    logic [15:0]    rd_r;         // Read data

    // Condition terms
    logic [NEL-1:0] setC;         // Pickup conditions
    logic [NEL-1:0] clrC;         // Reset conditions
    logic [15:0]    minV;         // Lowest main phase
    logic [15:0]    maxV;         // Highest main phase
    logic [15:0]    ph [3];       // Selected main phases
    logic           vaOk;         // Phase A live
    logic           vSupOk;       // Voltage supervision met
    logic           iSupOk;       // Current supervision met
    logic [15:0]    vNum;         // Voltage ratio numerator
    logic [15:0]    vDen;         // Voltage ratio denominator
    logic [15:0]    iNum;         // Current ratio numerator
    logic [15:0]    iDen;         // Current ratio denominator

    // Ratio num/den above pct percent
    function automatic logic ratioAbove(
        input logic [15:0] num,
        input logic [15:0] den,
        input logic [15:0] pct
    );
        logic [31:0] lhs;
        logic [31:0] rhs;
        lhs = num * PCT_ONE;
        rhs = pct * den;
        return lhs > rhs;
    endfunction

    // Ratio num/den below pct-1 percent
    function automatic logic ratioBelow(
        input logic [15:0] num,
        input logic [15:0] den,
        input logic [15:0] pct
    );
        logic [15:0] lowPct;
        logic [31:0] lhs;
        logic [31:0] rhs;
        lowPct = (pct > UB_HYS) ? pct - UB_HYS : 16'h0000;
        lhs = num * PCT_ONE;
        rhs = lowPct * den;
        return lhs < rhs;
    endfunction

    // Value times 100 against threshold times pct
    function automatic logic scaledAbove(
        input logic [15:0] v,
        input logic [15:0] thr,
        input logic [15:0] pct
    );
        logic [31:0] lhs;
        logic [31:0] rhs;
        lhs = v * PCT_ONE;
        rhs = thr * pct;
        return lhs > rhs;
    endfunction

    // Phase selection and extremes
    always_comb
    begin
        for (int p = 0; p < 3; p++)
        begin
            // Delta compares line-line, wye line-neutral
            ph[p] = cfg_r[CFG_DELTA] ? meas.vLl[p] : meas.vLn[p];
        end
        minV = ph[0];
        maxV = ph[0];
        for (int p = 1; p < 3; p++)
        begin
            if (ph[p] < minV)
            begin
                minV = ph[p];
            end
            if (ph[p] > maxV)
            begin
                maxV = ph[p];
            end
        end
    end

    // Ratio operands follow phase rotation
    always_comb
    begin
        if (cfg_r[CFG_ACB])
        begin
            // ACB: positive over negative
            vNum = meas.v1;
            vDen = meas.v2;
            iNum = meas.i1;
            iDen = meas.i2;
        end
        else
        begin
            // ABC: negative over positive
            vNum = meas.v2;
            vDen = meas.v1;
            iNum = meas.i2;
            iDen = meas.i1;
        end
    end

    // Supervision terms
    assign vSupOk = meas.v1 > vSup_r || meas.v2 > vSup_r;
    assign iSupOk = meas.i1 > iSup_r || meas.i2 > iSup_r;
    assign vaOk   = meas.vLn[0] > VA_MIN;

    // Pickup and reset conditions per element
    always_comb
    begin
        // Residual overcurrent, plain compare
        setC[RES_OC_ONE] = meas.iRes > pick_r[RES_OC_ONE];
        clrC[RES_OC_ONE] = !setC[RES_OC_ONE];
        setC[RES_OC_TWO] = meas.iRes > pick_r[RES_OC_TWO];
        clrC[RES_OC_TWO] = !setC[RES_OC_TWO];
        // Voltage unbalance, supervised ratio
        setC[VOLT_UNBAL] = vSupOk
            && ratioAbove(vNum, vDen, pick_r[VOLT_UNBAL]);
        clrC[VOLT_UNBAL] = !vSupOk
            || ratioBelow(vNum, vDen, pick_r[VOLT_UNBAL]);
        // Current unbalance, supervised ratio
        setC[CURR_UNBAL] = iSupOk
            && ratioAbove(iNum, iDen, pick_r[CURR_UNBAL]);
        clrC[CURR_UNBAL] = !iSupOk
            || ratioBelow(iNum, iDen, pick_r[CURR_UNBAL]);
        // Main undervoltage, any phase low
        setC[MAIN_UV] = minV < pick_r[MAIN_UV];
        clrC[MAIN_UV] = scaledAbove(minV, pick_r[MAIN_UV], UV_HYS);
        // Main overvoltage, any phase high
        setC[MAIN_OV] = maxV > pick_r[MAIN_OV];
        clrC[MAIN_OV] = 32'(maxV) * 32'(PCT_ONE) < 32'(pick_r[MAIN_OV]) * 32'(OV_HYS);
        // Auxiliary single-phase voltage
        setC[AUX_UV] = meas.vAux < pick_r[AUX_UV];
        clrC[AUX_UV] = scaledAbove(meas.vAux, pick_r[AUX_UV], UV_HYS);
        setC[AUX_OV] = meas.vAux > pick_r[AUX_OV];
        clrC[AUX_OV] = 32'(meas.vAux) * 32'(PCT_ONE) < 32'(pick_r[AUX_OV]) * 32'(OV_HYS);
        // Frequency, supervised by phase A
        setC[UNDER_FREQ] = vaOk && meas.freq < pick_r[UNDER_FREQ];
        clrC[UNDER_FREQ] = !vaOk || meas.freq > pick_r[UNDER_FREQ];
        setC[OVER_FREQ]  = vaOk && meas.freq > pick_r[OVER_FREQ];
        clrC[OVER_FREQ]  = !vaOk || meas.freq < pick_r[OVER_FREQ];
    end

    // Pickup latch: set wins, else hold until reset condition
    assign pu_nxt = setC | (pu_r & ~clrC);

    // Pickup flags
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            pu_r <= '0;
        end
        else if (enable)
        begin
            pu_r <= pu_nxt;
        end
    end

    // Cycle counters and trips
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            tr_r <= '0;
            for (int k = 0; k < NEL; k++)
            begin
                cnt_r[k] <= '0;
            end
        end
        else if (enable)
        begin
            for (int k = 0; k < NEL; k++)
            begin
                if (!pu_nxt[k])
                begin
                    // Early drop restarts the delay
                    cnt_r[k] <= '0;
                    tr_r[k]  <= 1'b0;
                end
                else
                begin
                    if (cycleTick && cnt_r[k] != CNT_MAX)
                    begin
                        // Count line cycles only
                        cnt_r[k] <= cnt_r[k] + 14'h0001;
                    end
                    // Continuous pickup for the delay trips
                    tr_r[k] <= cnt_r[k] >= dly_r[k];
                end
            end
        end
    end

    // Setting writes
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            vSup_r <= PICK_RST;
            iSup_r <= PICK_RST;
            cfg_r  <= CFG_RST;
            for (int k = 0; k < NEL; k++)
            begin
                pick_r[k] <= PICK_RST;
                dly_r[k]  <= DLY_RST;
            end
        end
        else if (enable && bus.wr)
        begin
            for (int k = 0; k < NEL; k++)
            begin
                if (bus.addr == A_PICK + 6'(k))
                begin
                    pick_r[k] <= bus.wdata;
                end
                if (bus.addr == A_DELAY + 6'(k))
                begin
                    dly_r[k] <= bus.wdata[13:0];
                end
            end
            if (bus.addr == A_VSUP)
            begin
                vSup_r <= bus.wdata;
            end
            if (bus.addr == A_ISUP)
            begin
                iSup_r <= bus.wdata;
            end
            if (bus.addr == A_CFG)
            begin
                cfg_r <= bus.wdata[1:0];
            end
        end
    end

    // Read data, valid only the cycle after the strobe
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            rd_r <= '0;
        end
        else if (enable)
        begin
            rd_r <= '0;
            if (bus.rd)
            begin
                for (int k = 0; k < NEL; k++)
                begin
                    if (bus.addr == A_PICK + 6'(k))
                    begin
                        rd_r <= pick_r[k];
                    end
                    if (bus.addr == A_DELAY + 6'(k))
                    begin
                        rd_r <= {2'h0, dly_r[k]};
                    end
                end
                case (bus.addr)
                    A_VSUP:   rd_r <= vSup_r;
                    A_ISUP:   rd_r <= iSup_r;
                    A_CFG:    rd_r <= {14'h0000, cfg_r};
                    A_PUSTAT: rd_r <= {6'h00, pu_r};
                    A_TRSTAT: rd_r <= {6'h00, tr_r};
                    default:  ;
                endcase
            end
        end
    end

    // Outputs straight from flops
    assign readData = rd_r;
    assign pickup   = pu_r;
    assign trip     = tr_r;

    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    // Overcurrent picks up the cycle after the compare
    property p_oc_pick;
        enable && meas.iRes > pick_r[RES_OC_TWO] |=> pu_r[RES_OC_TWO];
    endproperty
    a_oc_pick: assert property (p_oc_pick) else $error("oc two no pickup");

    // No voltage unbalance without supervision
    property p_vub_sup;
        enable && meas.v1 <= vSup_r && meas.v2 <= vSup_r |=> !pu_r[VOLT_UNBAL];
    endproperty
    a_vub_sup: assert property (p_vub_sup) else $error("vub without supv");

    // ABC rotation uses V2 over V1
    property p_vub_abc;
        enable && !cfg_r[CFG_ACB] && meas.v1 > vSup_r
            && 32'(meas.v2) * 32'(PCT_ONE) > 32'(pick_r[VOLT_UNBAL]) * 32'(meas.v1)
            |=> pu_r[VOLT_UNBAL];
    endproperty
    a_vub_abc: assert property (p_vub_abc) else $error("abc ratio wrong");

    // A trip never stands without its pickup
    property p_trip_pu;
        tr_r[CURR_UNBAL] |-> pu_r[CURR_UNBAL];
    endproperty
    a_trip_pu: assert property (p_trip_pu) else $error("trip w/o pickup");

    // Dropped pickup leaves a cleared counter
    property p_restart;
        !pu_r[MAIN_UV] |-> cnt_r[MAIN_UV] == 14'h0000;
    endproperty
    a_restart: assert property (p_restart) else $error("counter kept");

    // Counter moves only on a line cycle
    property p_tick;
        enable && !cycleTick && pu_nxt[MAIN_OV] |=> $stable(cnt_r[MAIN_OV]);
    endproperty
    a_tick: assert property (p_tick) else $error("count w/o tick");

    // Underfrequency needs live phase A
    property p_uf_va;
        enable && meas.vLn[0] <= VA_MIN |=> !pu_r[UNDER_FREQ];
    endproperty
    a_uf_va: assert property (p_uf_va) else $error("uf without va");

    // Overfrequency clears below threshold
    property p_of_clr;
        enable && meas.freq < pick_r[OVER_FREQ] |=> !pu_r[OVER_FREQ];
    endproperty
    a_of_clr: assert property (p_of_clr) else $error("of not cleared");

    // Delay zero: trip comes with pickup; checked after two held cycles
    sequence s_aux_hold;
        enable && pu_nxt[AUX_UV] && dly_r[AUX_UV] == 14'h0000;
    endsequence
    property p_aux_zero;
        s_aux_hold ##1 s_aux_hold |=> tr_r[AUX_UV];
    endproperty
    a_aux_zero: assert property (p_aux_zero) else $error("aux uv no trip");

endmodule // rtte_trip_elements

// >>> rtl/rtte_pkg.sv
package rtte_pkg;

    // Element count and widths
    localparam int NEL = 10;
    localparam int DW  = 16;
    localparam int AW  = 6;
    localparam int CW  = 14;

    // Element indices
    localparam int RES_OC_ONE = 0;
    localparam int RES_OC_TWO = 1;
    localparam int VOLT_UNBAL = 2;
    localparam int CURR_UNBAL = 3;
    localparam int MAIN_UV    = 4;
    localparam int MAIN_OV    = 5;
    localparam int AUX_UV     = 6;
    localparam int AUX_OV     = 7;
    localparam int UNDER_FREQ = 8;
    localparam int OVER_FREQ  = 9;

    // Register offsets (word index on the plain port)
    localparam logic [5:0] A_PICK   = 6'h00;
    localparam logic [5:0] A_DELAY  = 6'h10;
    localparam logic [5:0] A_VSUP   = 6'h20;
    localparam logic [5:0] A_ISUP   = 6'h21;
    localparam logic [5:0] A_CFG    = 6'h22;
    localparam logic [5:0] A_PUSTAT = 6'h28;
    localparam logic [5:0] A_TRSTAT = 6'h29;

    // Config field positions
    localparam int CFG_ACB   = 0;
    localparam int CFG_DELTA = 1;

    // Reset values
    localparam logic [15:0] PICK_RST = 16'h0000;
    localparam logic [13:0] DLY_RST  = 14'h0000;
    localparam logic [1:0]  CFG_RST  = 2'h0;

    // Phase A supervision, 10 V at 0.1 V per bit
    localparam logic [15:0] VA_MIN = 16'h0064;

    // Percent scale and hysteresis figures
    localparam logic [15:0] PCT_ONE = 16'h0064;
    localparam logic [15:0] UV_HYS  = 16'h0066;
    localparam logic [15:0] OV_HYS  = 16'h0062;
    localparam logic [15:0] UB_HYS  = 16'h0001;
    localparam logic [13:0] CNT_MAX = 14'h3fff;

    // Measured quantities from the upstream measurement logic
    typedef struct packed {
        logic [2:0][15:0] vLn;
        logic [2:0][15:0] vLl;
        logic [15:0]      vAux;
        logic [15:0]      freq;
        logic [15:0]      iRes;
        logic [15:0]      v1;
        logic [15:0]      v2;
        logic [15:0]      i1;
        logic [15:0]      i2;
    } rtte_meas_t;

    // Register port request
    typedef struct packed {
        logic [5:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } rtte_bus_t;

endpackage

// >>> testbench/tb.sv
`timescale 1ns/10ps
// Compare one value against its expectation and count the outcome
`define CHK(nm, ex, gt) begin \
    checks++; \
    if ((gt) !== (ex)) begin \
        error_cnt++; \
        $display("ERROR %s exp %h got %h", nm, ex, gt); \
    end \
end

module tb;
    import rtte_pkg::*;

    logic            clock;     // 50 MHz bench clock
    logic            reset;     // Synchronous reset, active high
    logic            enable;    // Clock enable of the block
    logic            cycleTick; // One pulse per power-system cycle
    rtte_meas_t      meas;      // Measured quantities
    rtte_bus_t       bus;       // Register port request
    logic [DW-1:0]   readData;  // Register read data
    logic [NEL-1:0]  pickup;    // Pickup flags
    logic [NEL-1:0]  trip;      // Trip flags
    int              error_cnt; // Mismatches seen
    int              checks;    // Comparisons made
    int              dly [NEL]; // Delay chosen per element
    // Thresholds per element, residual current, 0.1 V, 0.01 Hz or percent
    int pk [NEL] = '{500, 800, 5, 5, 1000, 1400, 1000, 1400, 5900, 6100};
    // Fault, hold and clear values per element
    // Overcurrent has no dead band: equality already drops it, so its hold stays above pickup
    int vt [NEL][3] = '{'{600, 550, 400}, '{900, 850, 400}, '{100, 45, 35}, '{100, 45, 35},
        '{900, 1010, 1021}, '{1500, 1390, 1371}, '{900, 1010, 1021}, '{1500, 1390, 1371},
        '{5800, 5900, 5901}, '{6200, 6100, 6099}};

    rtte_trip_elements dut (
        .clock     (clock),
        .reset     (reset),
        .enable    (enable),
        .cycleTick (cycleTick),
        .meas      (meas),
        .bus       (bus),
        .readData  (readData),
        .pickup    (pickup),
        .trip      (trip)
    );

    // Clock generator
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // Quiet system: 120 V everywhere, 60 Hz, no residual or sequence quantities
    function automatic rtte_meas_t base();
        rtte_meas_t m;
        m = '0;
        for (int p = 0; p < 3; p++)
        begin
            m.vLn[p] = 16'h04b0;
            m.vLl[p] = 16'h04b0;
        end
        m.vAux = 16'h04b0;
        m.freq = 16'h1770;
        return m;
    endfunction

    // Stimulus for element k in phase 0 fault, 1 hold, 2 clear
    function automatic rtte_meas_t stim(input int k, input int ph);
        rtte_meas_t m;
        m = base();
        case (k)
            0, 1: m.iRes = 16'(vt[k][ph]);
            2:
            begin
                m.v1 = 16'h03e8;
                m.v2 = 16'(vt[k][ph]);
            end
            3:
            begin
                m.i1 = 16'h03e8;
                m.i2 = 16'(vt[k][ph]);
            end
            4: m.vLn[1] = 16'(vt[k][ph]);
            5: m.vLn[2] = 16'(vt[k][ph]);
            6, 7: m.vAux = 16'(vt[k][ph]);
            default: m.freq = 16'(vt[k][ph]);
        endcase
        return m;
    endfunction

    // Trips expected after tk cycle ticks of continuous pickup
    function automatic logic [NEL-1:0] trip_exp(input logic [NEL-1:0] pk0, input int tk);
        logic [NEL-1:0] r;
        for (int j = 0; j < NEL; j++)
            r[j] = pk0[j] && (tk >= dly[j]);
        return r;
    endfunction

    // Wait n edges, then look just after the last one
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Apply new measurements at a clock edge
    task automatic drive(input rtte_meas_t m);
        @(posedge clock);
        meas <= m;
    endtask

    // One power-system cycle pulse
    task automatic tick();
        @(posedge clock);
        cycleTick <= 1'b1;
        @(posedge clock);
        cycleTick <= 1'b0;
    endtask

    // Register write, one cycle
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge clock);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus <= '0;
    endtask

    // Register read; data stand in the cycle after the strobe
    task automatic rd_chk(input logic [5:0] a, input logic [15:0] ex);
        @(posedge clock);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus <= '0;
        #1;
        `CHK("readData", ex, readData)
    endtask

    // Fault, timing, hold and clear of one element
    task automatic elem_test(input int k);
        logic [NEL-1:0] ex;
        ex = (k == 1) ? 10'h003 : (10'h001 << k);
        drive(stim(k, 0));
        settle(3);
        `CHK("pickup", ex, pickup)
        `CHK("trip", trip_exp(ex, 0), trip)
        rd_chk(A_PUSTAT, {6'h00, ex});
        for (int t = 1; t <= 4; t++)
        begin
            tick();
            settle(3);
            `CHK("trip", trip_exp(ex, t), trip)
        end
        rd_chk(A_TRSTAT, {6'h00, trip_exp(ex, 4)});
        drive(stim(k, 1));
        settle(3);
        `CHK("pickup", ex, pickup)
        drive(stim(k, 2));
        settle(3);
        `CHK("pickup", 10'h000, pickup)
        `CHK("trip", 10'h000, trip)
    endtask

    // Load thresholds, delays and supervision
    task automatic setup();
        for (int k = 0; k < NEL; k++)
        begin
            wr(A_PICK + 6'(k), 16'(pk[k]));
            wr(A_DELAY + 6'(k), 16'(dly[k]));
        end
        wr(A_VSUP, 16'h0064);
        wr(A_ISUP, 16'h0064);
        wr(A_CFG, 16'h0000);
    endtask

    // Print the counts and the verdict, then end
    task automatic stop_test();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Watchdog against a hang
    initial
    begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        stop_test();
    end

    // Main sequence
    initial
    begin
        rtte_meas_t m;
        logic [15:0] d;
        error_cnt = 0;
        checks = 0;
        reset = 1'b1;
        enable = 1'b1;
        cycleTick = 1'b0;
        bus = '0;
        meas = base();
        void'($urandom(32'h4238));
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        // Reset values and an unmapped place
        for (int k = 0; k < NEL; k++)
        begin
            rd_chk(A_PICK + 6'(k), PICK_RST);
            rd_chk(A_DELAY + 6'(k), {2'h0, DLY_RST});
        end
        rd_chk(A_CFG, {14'h0000, CFG_RST});
        wr(6'h3f, 16'hffff);
        rd_chk(6'h3f, 16'h0000);
        // Random readback, delay and config fields masked
        for (int i = 0; i < 8; i++)
        begin
            d = 16'($urandom);
            wr(A_PICK + 6'(i), d);
            rd_chk(A_PICK + 6'(i), d);
            wr(A_DELAY + 6'(i), d);
            rd_chk(A_DELAY + 6'(i), d & 16'h3fff);
        end
        wr(A_CFG, 16'hffff);
        rd_chk(A_CFG, 16'h0003);
        // Delays: instantaneous first element, random short ones elsewhere
        dly[0] = 0;
        for (int k = 1; k < NEL; k++)
            dly[k] = 1 + ($urandom % 3);
        // Zero delay corner on the auxiliary undervoltage as well
        dly[6] = 0;
        setup();
        settle(3);
        `CHK("pickup", 10'h000, pickup)
        for (int k = 0; k < NEL; k++)
            elem_test(k);
        // Sequences both at or below supervision
        m = base();
        m.v1 = 16'h0014;
        m.v2 = 16'h0064;
        m.i1 = 16'h0014;
        m.i2 = 16'h0064;
        drive(m);
        settle(3);
        `CHK("pickup", 10'h000, pickup)
        // Small reverse ratio picks up only with the other rotation
        m.v1 = 16'h03e8;
        m.v2 = 16'h0014;
        m.i1 = 16'h03e8;
        m.i2 = 16'h0014;
        drive(m);
        settle(3);
        `CHK("pickup", 10'h000, pickup)
        wr(A_CFG, 16'h0001);
        settle(3);
        `CHK("pickup", 10'h00c, pickup)
        wr(A_CFG, 16'h0000);
        drive(base());
        settle(3);
        // Low line-to-line voltage counts only in delta
        m = base();
        m.vLl[0] = 16'h0384;
        drive(m);
        settle(3);
        `CHK("pickup", 10'h000, pickup)
        wr(A_CFG, 16'h0002);
        settle(3);
        `CHK("pickup", 10'h010, pickup)
        wr(A_CFG, 16'h0000);
        drive(base());
        settle(3);
        // Underfrequency blocked by low phase A voltage
        m = stim(8, 0);
        m.vLn[0] = 16'h005a;
        drive(m);
        settle(3);
        `CHK("pickup", 10'h010, pickup)
        drive(base());
        settle(3);
        // Delay restarts after a dropout
        dly[4] = 3;
        wr(A_DELAY + 6'(4), 16'h0003);
        drive(stim(4, 0));
        settle(2);
        repeat (2) tick();
        drive(base());
        settle(3);
        drive(stim(4, 0));
        settle(2);
        repeat (2) tick();
        settle(3);
        `CHK("trip", 10'h000, trip)
        tick();
        settle(3);
        `CHK("trip", 10'h010, trip)
        drive(base());
        settle(3);
        // Enable low freezes the elements
        @(posedge clock);
        enable <= 1'b0;
        drive(stim(5, 0));
        settle(3);
        `CHK("pickup", 10'h000, pickup)
        @(posedge clock);
        enable <= 1'b1;
        settle(3);
        `CHK("pickup", 10'h020, pickup)
        drive(base());
        settle(3);
        stop_test();
    end

endmodule // tb
